// ---- include/omm_defines.vh ----
// Constants for the optical module management and sideband block.
// Assumes a 100 MHz system clock; included by bare name from hw/ files.
//
// Notes on behaviour
// - Transmit fault high when bias or output power exceeds alarm level, low otherwise.
// - Laser off while transmit disable is high or open, on while it is low.
// - Loss-of-signal output is 0 in normal reception and 1 when signal is lost.
// - Memory is one fixed 128-byte lower page plus upper pages picked by page select.
// - Flags and monitors sit in the lower page; ID and thresholds in upper pages.
// - Serial slave answers only at the single management bus address.
// - Serial interface is ready no later than 2000 ms after power-up or reset.
// - Monitor data are valid no later than 2000 ms after initialisation starts.
// - Transmit fault asserts no later than 200 ms after the fault arises.
// - Reduced power state entered within 100 ms after low power is requested.
// - Reduced power state left within 300 ms after the request is removed.
// - Per-lane receive, transmit power, bias, supply and temperature reported in memory.
// - Presence outputs at each single-lane end are tied to ground.
`ifndef OMM_DEFINES_VH
`define OMM_DEFINES_VH

// Clock rate
`define OMM_CLK_MHZ        100

// Timing figures as printed, and cycle counts for the init and low power ones
`define OMM_TINIT_MS       2000
`define OMM_TINIT_CYC      (`OMM_TINIT_MS * `OMM_CLK_MHZ * 1000)
`define OMM_TPDOWN_ON_MS   100
`define OMM_TPDOWN_ON_CYC  (`OMM_TPDOWN_ON_MS * `OMM_CLK_MHZ * 1000)
`define OMM_TPDOWN_OFF_MS  300
`define OMM_TPDOWN_OFF_CYC (`OMM_TPDOWN_OFF_MS * `OMM_CLK_MHZ * 1000)
`define OMM_TFAULT_MS      200
`define OMM_TINT_ON_MS     200
`define OMM_TINT_OFF_US    500
`define OMM_TSEL_US        100

// Serial bus address (7-bit form of the 8'ha0 write byte)
`define OMM_DEV_ADDR       7'h50

// Memory arrangement
`define OMM_LOWER_SIZE     128
`define OMM_PAGE_BITS      2

// Lower page offsets held in flops
`define OMM_OFF_STATUS     8'h02
`define OMM_OFF_FLAGS      8'h03
`define OMM_OFF_CTRL       8'h5d
`define OMM_OFF_PAGESEL    8'h7f

// Field positions
`define OMM_STAT_NOTREADY  0
`define OMM_STAT_INT       1
`define OMM_CTRL_OVERRIDE  0
`define OMM_CTRL_POWERSET  1

// Reset values
`define OMM_CTRL_RST       8'h00
`define OMM_PAGESEL_RST    8'h00

`endif

// ---- hw/omm_mem.v ----
// Paged management memory: bus port with registered read, monitor write port.
// Assumes one clock; contents are not reset.
`timescale 1ns/100ps
`include "omm_defines.vh"

module omm_mem #(
    parameter AW    = 10,
    parameter DEPTH = 640
) (
    // Clock
    input  wire          clk,
    // Bus port
    input  wire          aWe,
    input  wire [AW-1:0] aAddr,
    input  wire [7:0]    aWdata,
    output reg  [7:0]    aRdata,
    // Monitor port
    input  wire          bWe,
    input  wire [AW-1:0] bAddr,
    input  wire [7:0]    bWdata
);

    reg [7:0] mem [0:DEPTH-1];

    // Monitor write lands last, so fresh samples win a same-address clash
    always @(posedge clk) begin
        if (aWe)
            mem[aAddr] <= aWdata;
        if (bWe)
            mem[bAddr] <= bWdata;
        aRdata <= mem[aAddr];
    end

endmodule // omm_mem

// ---- hw/omm_sideband.v ----
// Management and sideband control of the four-lane optical module end.
// Assumes all pins already synchronous to clk_sys; SCL phases last >= 3 clocks.
`timescale 1ns/100ps
`include "omm_defines.vh"

module omm_sideband #(
    parameter LANES         = 4,
    parameter PAGE_BITS     = `OMM_PAGE_BITS,
    parameter INIT_CYCLES   = `OMM_TINIT_CYC,
    parameter PDOWN_ON_CYC  = `OMM_TPDOWN_ON_CYC,
    parameter PDOWN_OFF_CYC = `OMM_TPDOWN_OFF_CYC
) (
    // Clock and reset
    input  wire             clk_sys,
    input  wire             rstn,
    // Host control pins
    input  wire             module_select_n,
    input  wire             module_reset_n,
    input  wire             low_power_in,
    input  wire [LANES-1:0] tx_disable,
    // Two-wire serial bus
    input  wire             scl_in,
    input  wire             sda_in,
    output reg              sda_out,
    output reg              sda_oe,
    // Host status pins
    output reg              interrupt_out_n,
    output reg              module_present_n,
    output reg  [LANES-1:0] presence_tie_out,
    output reg  [LANES-1:0] tx_fault,
    output reg  [LANES-1:0] rx_los,
    // Optics side
    input  wire [LANES-1:0] bias_alarm,
    input  wire [LANES-1:0] power_alarm,
    input  wire [LANES-1:0] rx_signal_lost,
    output reg  [LANES-1:0] laser_on,
    output reg              low_power_state,
    output reg              monitor_valid,
    // Monitor sample port into the lower page
    input  wire             mon_write,
    input  wire [6:0]       mon_addr,
    input  wire [7:0]       mon_data
);

    localparam AW    = PAGE_BITS + 8;
    localparam DEPTH = (1 + (1 << PAGE_BITS)) * `OMM_LOWER_SIZE;
    localparam [AW-1:0] LOWER = `OMM_LOWER_SIZE;

    localparam [2:0] ST_IDLE  = 3'd0;
    localparam [2:0] ST_ADDR  = 3'd1;
    localparam [2:0] ST_AACK  = 3'd2;
    localparam [2:0] ST_WBYTE = 3'd3;
    localparam [2:0] ST_WACK  = 3'd4;
    localparam [2:0] ST_RBYTE = 3'd5;
    localparam [2:0] ST_RACK  = 3'd6;

    reg  [31:0]    initCnt;
    reg            initDone;
    reg  [31:0]    lpCnt;
    reg            selected;
    reg            sclD, sclD2, sdaD, sdaD2;
    reg  [2:0]     state;
    reg  [3:0]     bitCnt;
    reg  [1:0]     ackPhase;
    reg  [7:0]     shReg;
    reg  [7:0]     txByte;
    reg  [7:0]     ptr;
    reg            firstByte;
    reg  [7:0]     ctrl;
    reg  [7:0]     pageSel;
    reg  [7:0]     flags;
    reg            flagClr;
    reg            memWe;
    reg  [AW-1:0]  memWaddr;
    reg  [7:0]     memWdata;
    reg  [7:0]     readByte;
    wire [7:0]     memRdata;
    wire [AW-1:0]  memAddr;
    wire           lpRequest;
    wire           busOn;
    wire           sclRise, sclFall, startCond, stopCond;
    wire [7:0]     rxByte;
    wire [7:0]     statusByte;

    // Upper offsets map behind the lower page through the page select
    assign memAddr = ptr[7] ? ({1'b0, pageSel[PAGE_BITS-1:0], ptr[6:0]} + LOWER)
                            : {{(AW-8){1'b0}}, ptr};

    assign sclRise   = sclD & ~sclD2;
    assign sclFall   = ~sclD & sclD2;
    assign startCond = sclD & sclD2 & sdaD2 & ~sdaD;
    assign stopCond  = sclD & sclD2 & ~sdaD2 & sdaD;
    assign rxByte    = {shReg[6:0], sdaD};
    assign busOn     = initDone & selected;
    assign statusByte = {6'h00, |flags, ~initDone};
    assign lpRequest = ctrl[`OMM_CTRL_OVERRIDE] ? ctrl[`OMM_CTRL_POWERSET] : low_power_in;

    // Read mux: flag, status and control bytes live in flops
    always @* begin
        case (ptr)
            `OMM_OFF_STATUS:  readByte = statusByte;
            `OMM_OFF_FLAGS:   readByte = flags;
            `OMM_OFF_CTRL:    readByte = ctrl;
            `OMM_OFF_PAGESEL: readByte = pageSel;
            default:          readByte = memRdata;
        endcase
    end

    omm_mem #(
        .AW    (AW),
        .DEPTH (DEPTH)
    ) uMem (
        .clk    (clk_sys),
        .aWe    (memWe),
        .aAddr  (memWe ? memWaddr : memAddr),
        .aWdata (memWdata),
        .aRdata (memRdata),
        .bWe    (mon_write),
        .bAddr  ({{(AW-7){1'b0}}, mon_addr}),
        .bWdata (mon_data)
    );

    // Initialisation timer; module reset pin restarts it like rstn
    always @(posedge clk_sys) begin
        if (!rstn || !module_reset_n) begin
            initCnt       <= 32'h0000_0000;
            initDone      <= 1'b0;
            monitor_valid <= 1'b0;
        end else if (!initDone) begin
            initCnt <= initCnt + 32'h0000_0001;
            if (initCnt == INIT_CYCLES - 1) begin
                initDone      <= 1'b1;
                monitor_valid <= 1'b1;
            end
        end
    end

    // Pin-side status: one-cycle latency, two from alarm to interrupt, is far inside every allowance
    always @(posedge clk_sys) begin
        if (!rstn) begin
            tx_fault         <= {LANES{1'b0}};
            rx_los           <= {LANES{1'b0}};
            laser_on         <= {LANES{1'b0}};
            presence_tie_out <= {LANES{1'b0}};
            module_present_n <= 1'b0;
            interrupt_out_n  <= 1'b1;
            flags            <= 8'h00;
            selected         <= 1'b0;
        end else begin
            tx_fault         <= bias_alarm | power_alarm;
            rx_los           <= rx_signal_lost;
            laser_on         <= ~tx_disable;
            presence_tie_out <= {LANES{1'b0}};
            module_present_n <= 1'b0;
            selected         <= ~module_select_n;
            // Set beats clear so an alarm during the flag read is kept
            flags <= (flags & {8{~flagClr}})
                   | {bias_alarm | power_alarm, rx_signal_lost};
            interrupt_out_n <= ~(|flags);
        end
    end

    // Low power entry and exit after their own delays
    always @(posedge clk_sys) begin
        if (!rstn) begin
            lpCnt           <= 32'h0000_0000;
            low_power_state <= 1'b0;
        end else if (lpRequest == low_power_state) begin
            lpCnt <= 32'h0000_0000;
        end else begin
            lpCnt <= lpCnt + 32'h0000_0001;
            if (lpRequest && lpCnt == PDOWN_ON_CYC - 1) begin
                low_power_state <= 1'b1;
                lpCnt           <= 32'h0000_0000;
            end
            if (!lpRequest && lpCnt == PDOWN_OFF_CYC - 1) begin
                low_power_state <= 1'b0;
                lpCnt           <= 32'h0000_0000;
            end
        end
    end

    // Bus line history for edge and condition detection
    always @(posedge clk_sys) begin
        if (!rstn) begin
            sclD  <= 1'b1;
            sclD2 <= 1'b1;
            sdaD  <= 1'b1;
            sdaD2 <= 1'b1;
        end else begin
            sclD  <= scl_in;
            sclD2 <= sclD;
            sdaD  <= sda_in;
            sdaD2 <= sdaD;
        end
    end

    // Two-wire slave; a lost select or init aborts and frees SDA at once
    always @(posedge clk_sys) begin
        if (!rstn) begin
            state     <= ST_IDLE;
            bitCnt    <= 4'h0;
            ackPhase  <= 2'd0;
            shReg     <= 8'h00;
            txByte    <= 8'h00;
            ptr       <= 8'h00;
            firstByte <= 1'b0;
            ctrl      <= `OMM_CTRL_RST;
            pageSel   <= `OMM_PAGESEL_RST;
            sda_out   <= 1'b0;
            sda_oe    <= 1'b0;
            flagClr   <= 1'b0;
            memWe     <= 1'b0;
            memWaddr  <= {AW{1'b0}};
            memWdata  <= 8'h00;
        end else begin
            flagClr <= 1'b0;
            memWe   <= 1'b0;
            sda_out <= 1'b0;
            if (!busOn) begin
                state  <= ST_IDLE;
                sda_oe <= 1'b0;
            end else if (startCond) begin
                state  <= ST_ADDR;
                bitCnt <= 4'h0;
                sda_oe <= 1'b0;
            end else if (stopCond) begin
                state  <= ST_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        sda_oe <= 1'b0;
                    end
                    ST_ADDR: begin
                        if (sclRise) begin
                            shReg  <= rxByte;
                            bitCnt <= bitCnt + 4'h1;
                            if (bitCnt == 4'h7) begin
                                ackPhase  <= 2'd0;
                                firstByte <= ~sdaD;
                                if (shReg[6:0] == `OMM_DEV_ADDR)
                                    state <= ST_AACK;
                                else
                                    state <= ST_IDLE;
                            end
                        end
                    end
                    ST_AACK: begin
                        if (sclFall && ackPhase == 2'd0) begin
                            sda_oe   <= 1'b1;
                            ackPhase <= 2'd1;
                        end else if (sclFall) begin
                            bitCnt <= 4'h0;
                            if (firstByte) begin
                                state  <= ST_WBYTE;
                                sda_oe <= 1'b0;
                            end else begin
                                state   <= ST_RBYTE;
                                txByte  <= readByte;
                                sda_oe  <= ~readByte[7];
                                flagClr <= (ptr == `OMM_OFF_FLAGS);
                            end
                        end
                    end
                    ST_WBYTE: begin
                        if (sclRise) begin
                            shReg  <= rxByte;
                            bitCnt <= bitCnt + 4'h1;
                            if (bitCnt == 4'h7) begin
                                state     <= ST_WACK;
                                ackPhase  <= 2'd0;
                                firstByte <= 1'b0;
                                if (firstByte) begin
                                    ptr <= rxByte;
                                end else begin
                                    ptr <= ptr + 8'h01;
                                    if (ptr == `OMM_OFF_CTRL)
                                        ctrl <= rxByte;
                                    else if (ptr == `OMM_OFF_PAGESEL)
                                        pageSel <= rxByte;
                                    else if (ptr != `OMM_OFF_STATUS &&
                                             ptr != `OMM_OFF_FLAGS) begin
                                        memWe    <= 1'b1;
                                        memWaddr <= memAddr;
                                        memWdata <= rxByte;
                                    end
                                end
                            end
                        end
                    end
                    ST_WACK: begin
                        if (sclFall && ackPhase == 2'd0) begin
                            sda_oe   <= 1'b1;
                            ackPhase <= 2'd1;
                        end else if (sclFall) begin
                            sda_oe <= 1'b0;
                            bitCnt <= 4'h0;
                            state  <= ST_WBYTE;
                        end
                    end
                    ST_RBYTE: begin
                        if (sclRise) begin
                            bitCnt <= bitCnt + 4'h1;
                            if (bitCnt == 4'h7) begin
                                state    <= ST_RACK;
                                ackPhase <= 2'd0;
                                ptr      <= ptr + 8'h01;
                            end
                        end else if (sclFall) begin
                            sda_oe <= ~txByte[3'd7 - bitCnt[2:0]];
                        end
                    end
                    ST_RACK: begin
                        if (sclFall && ackPhase == 2'd0) begin
                            sda_oe   <= 1'b0; // Master owns the ack bit
                            ackPhase <= 2'd1;
                        end else if (sclRise && ackPhase == 2'd1) begin
                            if (sdaD)
                                state <= ST_IDLE; // Not acked: read ends
                            else
                                ackPhase <= 2'd2;
                        end else if (sclFall && ackPhase == 2'd2) begin
                            state   <= ST_RBYTE;
                            bitCnt  <= 4'h0;
                            txByte  <= readByte;
                            sda_oe  <= ~readByte[7];
                            flagClr <= (ptr == `OMM_OFF_FLAGS);
                        end
                    end
                    default: begin
                        state  <= ST_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule // omm_sideband

// ---- testbench/omm_sideband_props.sv ----
// Checker for the sideband block, watching its ports only.
// Assumes synchronous active-low rstn and short counts from the bench.
`timescale 1ns/100ps
module omm_sideband_props #(
    parameter INIT_CYCLES   = 20,
    parameter PDOWN_ON_CYC  = 5,
    parameter PDOWN_OFF_CYC = 7
) (
    // Clock and reset
    input wire       clk_sys,
    input wire       rstn,
    // Host pins
    input wire       module_select_n,
    input wire       module_reset_n,
    input wire       low_power_in,
    input wire [3:0] tx_disable,
    input wire       sda_oe,
    input wire       interrupt_out_n,
    input wire       module_present_n,
    input wire [3:0] presence_tie_out,
    input wire [3:0] tx_fault,
    input wire [3:0] rx_los,
    // Optics side
    input wire [3:0] bias_alarm,
    input wire [3:0] power_alarm,
    input wire [3:0] rx_signal_lost,
    input wire [3:0] laser_on,
    input wire       low_power_state,
    input wire       monitor_valid
);
    integer initCnt;
    integer lpOn;
    integer lpOff;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Run lengths; saturation keeps the lpOn and lpOff runs from wrapping
    always @(posedge clk_sys) begin
        initCnt <= (!rstn || !module_reset_n) ? 0 : initCnt + 1;
        lpOn <= (!rstn || !low_power_in) ? 0 : (lpOn > PDOWN_ON_CYC + 4 ? lpOn : lpOn + 1);
        lpOff <= (!rstn || low_power_in) ? 0 : (lpOff > PDOWN_OFF_CYC + 4 ? lpOff : lpOff + 1);
    end
    fault_track_a: assert property ($past(rstn) |->
        tx_fault == $past(bias_alarm | power_alarm)) else $error("transmit fault wrong");
    laser_track_a: assert property ($past(rstn) |->
        laser_on == ~$past(tx_disable)) else $error("laser state wrong");
    los_track_a: assert property ($past(rstn) |->
        rx_los == $past(rx_signal_lost)) else $error("loss of signal wrong");
    presence_tie_a: assert property (presence_tie_out == 4'h0 && !module_present_n)
        else $error("presence not tied low");
    int_assert_a: assert property (|(bias_alarm | power_alarm) |-> ##[1:3] !interrupt_out_n)
        else $error("interrupt not raised");
    sel_quiet_a: assert property (module_select_n [*3] |-> !sda_oe)
        else $error("data driven while deselected");
    init_quiet_a: assert property (!monitor_valid [*2] |-> !sda_oe)
        else $error("data driven before ready");
    valid_early_a: assert property (monitor_valid |-> initCnt >= INIT_CYCLES - 2)
        else $error("monitor valid too early");
    valid_late_a: assert property (initCnt >= INIT_CYCLES + 3 |-> monitor_valid)
        else $error("monitor valid too late");
    lp_enter_a: assert property (lpOn >= PDOWN_ON_CYC + 2 |-> low_power_state)
        else $error("reduced power not entered");
    lp_exit_a: assert property (lpOff >= PDOWN_OFF_CYC + 2 |-> !low_power_state)
        else $error("reduced power not left");
    cover property ($rose(monitor_valid));
    cover property ($rose(sda_oe));
    cover property ($rose(low_power_state));
    cover property ($fell(interrupt_out_n));
endmodule // omm_sideband_props

bind omm_sideband omm_sideband_props #(.INIT_CYCLES(INIT_CYCLES),
    .PDOWN_ON_CYC(PDOWN_ON_CYC), .PDOWN_OFF_CYC(PDOWN_OFF_CYC)) omm_sideband_props_inst (.*);

// ---- testbench/omm_host_model.sv ----
// Two-wire bus master standing in for the host board controller.
// Assumes the bench resolves SDA as open drain with a pull-up.
`timescale 1ns/100ps
module omm_host_model (
    // Clock
    input wire clk_sys,
    // Bus lines
    input wire sdaLine,
    output reg scl,
    output reg sdaDrv
);
    initial {scl, sdaDrv} = 2'b11;
    // Signals move only just after an edge
    task tick(input integer n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Start or repeated start, SDA falls while SCL high
    task start;
        begin
            sdaDrv <= 1'b1;
            tick(4);
            scl <= 1'b1;
            tick(4);
            sdaDrv <= 1'b0;
            tick(4);
            scl <= 1'b0;
            tick(1);
        end
    endtask
    // Four-clock phases keep above the three-clock minimum
    task bitx(input b, output r);
        begin
            sdaDrv <= b;
            tick(4);
            scl <= 1'b1;
            tick(4);
            r = sdaLine;
            scl <= 1'b0;
            tick(1);
        end
    endtask
    task stop;
        begin
            sdaDrv <= 1'b0;
            tick(4);
            scl <= 1'b1;
            tick(4);
            sdaDrv <= 1'b1;
            tick(4);
        end
    endtask
    task wbyte(input [7:0] d, output ack);
        integer i;
        reg r;
        begin
            for (i = 7; i >= 0; i = i - 1)
                bitx(d[i], r);
            bitx(1'b1, r);
            ack = ~r;
        end
    endtask
    // Single-byte read, NACK ends it
    task rbyte(output [7:0] d);
        integer i;
        reg r;
        begin
            for (i = 7; i >= 0; i = i - 1)
                bitx(1'b1, d[i]);
            bitx(1'b1, r);
        end
    endtask
endmodule // omm_host_model

// ---- testbench/omm_sideband_bench.sv ----
// Self-checking bench for the sideband block with a bus master model.
// Assumes the checker is bound; long counts shortened by parameters.
`timescale 1ns/100ps
module omm_sideband_bench;
    localparam INIT = 20;
    localparam PON  = 5;
    localparam POFF = 7;
    reg        clk_sys, rstn, moduleSelectN, moduleResetN, lowPowerIn, monWrite, k;
    reg  [3:0] txDisable, biasAlarm, powerAlarm, rxSignalLost, b, p, l, d, accF, accL;
    reg  [6:0] monAddr;
    reg  [7:0] monData, s, v;
    wire       scl, sdaDrv, sdaOut, sdaOe, intN, presN, lpState, monValid;
    wire [3:0] presTie, txFault, rxLos, laserOn;
    wire       sdaLine = sdaDrv & ~(sdaOe & ~sdaOut);
    integer    errorCnt = 0, samplesChecked = 0, i, n;

    omm_sideband #(.INIT_CYCLES(INIT), .PDOWN_ON_CYC(PON), .PDOWN_OFF_CYC(POFF))
    omm_sideband_inst (.clk_sys(clk_sys), .rstn(rstn), .module_select_n(moduleSelectN),
        .module_reset_n(moduleResetN), .low_power_in(lowPowerIn), .tx_disable(txDisable),
        .scl_in(scl), .sda_in(sdaLine), .sda_out(sdaOut), .sda_oe(sdaOe),
        .interrupt_out_n(intN), .module_present_n(presN), .presence_tie_out(presTie),
        .tx_fault(txFault), .rx_los(rxLos), .bias_alarm(biasAlarm), .power_alarm(powerAlarm),
        .rx_signal_lost(rxSignalLost), .laser_on(laserOn), .low_power_state(lpState),
        .monitor_valid(monValid), .mon_write(monWrite), .mon_addr(monAddr), .mon_data(monData));
    omm_host_model omm_host_model_inst (.clk_sys(clk_sys), .sdaLine(sdaLine), .scl(scl),
        .sdaDrv(sdaDrv));

    function [7:0] lfsr(input [7:0] x);
        lfsr = {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    function [3:0] expLaser(input [3:0] dis);
        expLaser = ~dis;
    endfunction
    function [7:0] expFlags(input [3:0] f, input [3:0] los);
        expFlags = {f, los};
    endfunction
    task chk(input [8*10-1:0] what, input [7:0] exp, got);
        begin
            samplesChecked = samplesChecked + 1;
            if (got !== exp) begin
                errorCnt = errorCnt + 1;
                $display("mismatch %0s expected %h seen %h", what, exp, got);
            end
        end
    endtask
    task waitc(input integer n);
        begin
            repeat (n) @(posedge clk_sys);
            #1;
        end
    endtask
    // Offset byte, then one or two data bytes at rising pointer
    task wr(input [7:0] dev, off, d0, d1, input two, output ack);
        begin
            @(posedge clk_sys);
            omm_host_model_inst.start;
            omm_host_model_inst.wbyte(dev, ack);
            if (ack) begin
                omm_host_model_inst.wbyte(off, k);
                omm_host_model_inst.wbyte(d0, k);
                if (two)
                    omm_host_model_inst.wbyte(d1, k);
            end
            omm_host_model_inst.stop;
        end
    endtask
    task rd(input [7:0] off, output [7:0] dat);
        begin
            @(posedge clk_sys);
            omm_host_model_inst.start;
            omm_host_model_inst.wbyte(8'ha0, k);
            omm_host_model_inst.wbyte(off, k);
            omm_host_model_inst.start;
            omm_host_model_inst.wbyte(8'ha1, k);
            omm_host_model_inst.rbyte(dat);
            omm_host_model_inst.stop;
        end
    endtask
    task final_report;
        begin
            $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
            if (errorCnt == 0 && samplesChecked > 0)
                $display("TB: PASS");
            else
                $display("TB: FAIL");
            $finish;
        end
    endtask
    // Watchdog, about five times the expected run
    initial begin
        repeat (40000) @(posedge clk_sys);
        errorCnt = errorCnt + 1;
        final_report;
    end
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // Main sequence; open transmit disable is modelled as high
    initial begin
        {rstn, moduleSelectN, lowPowerIn, monWrite, moduleResetN} = 5'h01;
        {biasAlarm, powerAlarm, rxSignalLost} = 12'h000;
        txDisable = 4'hf;
        {monAddr, monData} = 15'h0000;
        s = 8'h24;
        {accF, accL} = 8'h00;
        repeat (12) @(posedge clk_sys);
        rstn <= 1'b1;
        chk("presence", 8'h00, {presN, presTie});
        chk("intIdle", 8'h01, intN);
        n = 0;
        while (monValid !== 1'b1 && n < INIT + 10) begin
            @(posedge clk_sys);
            n = n + 1;
        end
        chk("initTime", 8'h01, n >= INIT - 1 && n <= INIT + 2);
        $display("test init done");
        wr(8'ha2, 8'h10, 8'h00, 8'h00, 1'b0, k);
        chk("otherAddr", 8'h00, k);
        moduleSelectN <= 1'b1;
        wr(8'ha0, 8'h10, 8'h00, 8'h00, 1'b0, k);
        chk("deselect", 8'h00, k);
        moduleSelectN <= 1'b0;
        wr(8'ha0, 8'h10, 8'ha5, 8'h5a, 1'b1, k);
        chk("ownAddr", 8'h01, k);
        $display("test address done");
        for (i = 0; i < 4; i = i + 1) begin
            wr(8'ha0, 8'h7f, i, 8'h00, 1'b0, k);
            wr(8'ha0, 8'h80, 8'h30 + i, 8'h00, 1'b0, k);
        end
        for (i = 0; i < 4; i = i + 1) begin
            wr(8'ha0, 8'h7f, i, 8'h00, 1'b0, k);
            rd(8'h80, v);
            chk("upperPage", 8'h30 + i, v);
        end
        rd(8'h10, v);
        chk("lowerPage", 8'ha5, v);
        rd(8'h11, v);
        chk("pointerInc", 8'h5a, v);
        @(posedge clk_sys);
        s = lfsr(s);
        monWrite <= 1'b1;
        monAddr <= 7'h22;
        monData <= s;
        @(posedge clk_sys);
        monWrite <= 1'b0;
        rd(8'h22, v);
        chk("monitor", s, v);
        $display("test memory done");
        for (i = 0; i < 32; i = i + 1) begin
            @(posedge clk_sys);
            s = lfsr(s);
            b = s[3:0] & {4{s[7]}};
            p = s[5:2] & {4{s[0]}};
            l = s[7:4];
            d = s[6:3];
            biasAlarm <= b;
            powerAlarm <= p;
            rxSignalLost <= l;
            txDisable <= d;
            accF = accF | b | p;
            accL = accL | l;
            waitc(1);
            chk("txFault", b | p, txFault);
            chk("laserOn", expLaser(d), laserOn);
            chk("rxLos", l, rxLos);
        end
        @(posedge clk_sys);
        {biasAlarm, powerAlarm, rxSignalLost} <= 12'h000;
        repeat (3) @(posedge clk_sys);
        chk("intLow", (accF | accL) == 4'h0, intN);
        $display("test pins done");
        rd(8'h03, v);
        chk("flags", expFlags(accF, accL), v);
        repeat (3) @(posedge clk_sys);
        chk("intClear", 8'h01, intN);
        rd(8'h03, v);
        chk("flagsClear", 8'h00, v);
        rd(8'h02, v);
        chk("status", 8'h00, v);
        $display("test flags done");
        @(posedge clk_sys);
        lowPowerIn <= 1'b1;
        waitc(2);
        chk("lpEarly", 8'h00, lpState);
        waitc(PON + 2);
        chk("lpOn", 8'h01, lpState);
        @(posedge clk_sys);
        lowPowerIn <= 1'b0;
        waitc(2);
        chk("lpHold", 8'h01, lpState);
        waitc(POFF + 2);
        chk("lpOff", 8'h00, lpState);
        $display("test power done");
        @(posedge clk_sys);
        moduleResetN <= 1'b0;
        repeat (200) @(posedge clk_sys);
        moduleResetN <= 1'b1;
        chk("modReset", 8'h00, monValid);
        waitc(INIT + 1);
        chk("reInit", 8'h01, monValid);
        $display("test reset done");
        final_report;
    end
endmodule // omm_sideband_bench
